// ### hw/ncr_top.sv
// oscillator control registers, accumulator, output stage and bus slave
// Overview of operation
// - alternate pin select bit relocates output
// - control bit 7 enables the oscillator
// - control bit 5 reads output level only
// - control bit 4 inverts output polarity
// - control bit 0 picks pulse or toggle mode
// - clock bits 7..5 set pulse width 1..128
// - pulse width only used in pulse mode
// - clock bits 1..0 choose accumulator clock
// - clock bits 4..2 read zero, ignore writes
// - low byte maps accumulator bits 7..0
// - high byte maps accumulator bits 15..8
// - upper bits 3..0 map accumulator 19..16
// - upper bits 7..4 read zero, ignore writes
// - reset clears every oscillator register
`timescale 1ns/1ps
module ncr_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk_i,
    input  wire logic              arst_n_i,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    output logic [1:0]             s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    // asynchronous accumulator clock sources
    input  wire logic              fast_internal_oscillator_i,
    input  wire logic              logic_cell_one_output_i,
    input  wire logic              external_osc_clock_pin_i,
    // oscillator output to peripherals and to the two pin locations
    output logic                   osc_output_level_o,
    output logic                   pin_main_out_o,
    output logic                   pin_main_oe_n_o,
    output logic                   pin_alt_out_o,
    output logic                   pin_alt_oe_n_o,
    output logic                   irq_o
);

    // address decode shared by the read and write paths
    function automatic ncr_pkg::ncr_sel_t reg_sel(
        input logic [ADDR_W-1:0] addr
    );
        logic [7:0] a;
        a = addr[7:0];
        case (a)
            ncr_pkg::OFF_CONTROL:   reg_sel = ncr_pkg::SEL_CONTROL;
            ncr_pkg::OFF_CLOCK_SEL: reg_sel = ncr_pkg::SEL_CLOCK_SEL;
            ncr_pkg::OFF_ACC_LOW:   reg_sel = ncr_pkg::SEL_ACC_LOW;
            ncr_pkg::OFF_ACC_HIGH:  reg_sel = ncr_pkg::SEL_ACC_HIGH;
            ncr_pkg::OFF_ACC_UPPER: reg_sel = ncr_pkg::SEL_ACC_UPPER;
            ncr_pkg::OFF_INCREMENT: reg_sel = ncr_pkg::SEL_INCREMENT;
            ncr_pkg::OFF_ALT_PIN:   reg_sel = ncr_pkg::SEL_ALT_PIN;
            ncr_pkg::OFF_IRQ_STAT:  reg_sel = ncr_pkg::SEL_IRQ_STAT;
            ncr_pkg::OFF_IRQ_MASK:  reg_sel = ncr_pkg::SEL_IRQ_MASK;
            default:                reg_sel = ncr_pkg::SEL_NONE;
        endcase
    endfunction

    // register state
    ncr_pkg::ncr_ctrl_t            ctrl_reg;       // enable/oe/pol/mode
    ncr_pkg::ncr_clk_t             clk_reg;        // width and source
    logic [ncr_pkg::ACC_W-1:0]     acc_reg;        // phase accumulator
    logic [ncr_pkg::INC_W-1:0]     inc_reg;        // increment value
    logic                          alt_sel_reg;    // 1 = alternate pin
    logic                          stat_reg;       // overflow sticky flag
    logic                          mask_reg;       // overflow irq mask
    logic                          toggle_reg;     // toggle-mode flip-flop
    logic [ncr_pkg::PULSE_W-1:0]   pulse_cnt_reg;  // pulse ticks remaining
    logic                          level_reg;      // polarity-applied output

    // bus handshake state
    logic                          aw_held_reg;
    logic                          w_held_reg;
    logic [ADDR_W-1:0]             awaddr_reg;
    logic [31:0]                   wdata_reg;
    logic [3:0]                    wstrb_reg;
    logic                          awready_reg;
    logic                          wready_reg;
    logic                          bvalid_reg;
    logic [1:0]                    bresp_reg;
    logic                          arready_reg;
    logic                          rvalid_reg;
    logic [31:0]                   rdata_reg;
    logic [1:0]                    rresp_reg;

    // clock source synchronisers and edge detect
    logic [2:0]                    src_async;
    logic [2:0]                    src_meta_reg;   // first stage only
    logic [2:0]                    src_sync_reg;   // second stage
    logic [2:0]                    src_prev_reg;   // for rising edge
    logic [2:0]                    src_rise;
    logic                          tick;           // one accumulator clock

    // write path decode
    logic                          wr_do;
    ncr_pkg::ncr_sel_t             wr_sel;
    logic                          wr_lane0;
    logic                          wr_lane1;
    logic [ncr_pkg::ACC_W:0]       acc_sum;        // carry and new value
    logic                          overflow;       // carry out on a tick
    logic                          active;         // unpolarised output
    logic [ncr_pkg::PULSE_W-1:0]   pulse_len;

    assign src_async = {external_osc_clock_pin_i, logic_cell_one_output_i,
                        fast_internal_oscillator_i};

    // two-flop synchronisers, one per asynchronous source
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_sync
            always_ff @(posedge clk_i or negedge arst_n_i)
            begin
                if (!arst_n_i)
                begin
                    src_meta_reg[g] <= 1'b0;
                    src_sync_reg[g] <= 1'b0;
                    src_prev_reg[g] <= 1'b0;
                end
                else
                begin
                    src_meta_reg[g] <= src_async[g];
                    src_sync_reg[g] <= src_meta_reg[g];
                    src_prev_reg[g] <= src_sync_reg[g];
                end
            end
            assign src_rise[g] = src_sync_reg[g] & ~src_prev_reg[g];
        end
    endgenerate

    // accumulator clock selection
    always_comb
    begin
        case (clk_reg.cks)
            ncr_pkg::CKS_FAST_OSC: tick = src_rise[0];
            ncr_pkg::CKS_SYSTEM:   tick = 1'b1;
            ncr_pkg::CKS_CELL_ONE: tick = src_rise[1];
            ncr_pkg::CKS_EXT_PIN:  tick = src_rise[2];
            default:               tick = 1'b0;
        endcase
    end

    // write decode and adder
    assign wr_do    = aw_held_reg & w_held_reg & ~bvalid_reg;
    assign wr_sel   = reg_sel(awaddr_reg);
    assign wr_lane0 = wr_do & wstrb_reg[0];
    assign wr_lane1 = wr_do & wstrb_reg[1];
    assign acc_sum  = {1'b0, acc_reg} + {5'h00, inc_reg};
    assign overflow = ctrl_reg.en & tick & acc_sum[ncr_pkg::ACC_W];
    assign pulse_len = ncr_pkg::PULSE_W'(1) << clk_reg.pws;
    assign active = ctrl_reg.pfm ? (pulse_cnt_reg != '0)
                                 : toggle_reg;

    // control and configuration registers
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ctrl_reg    <= '0;
            clk_reg     <= '0;
            inc_reg     <= '0;
            alt_sel_reg <= 1'b0;
            mask_reg    <= 1'b0;
        end
        else
        begin
            if (wr_lane0)
            begin
                case (wr_sel)
                    ncr_pkg::SEL_CONTROL:
                    begin
                        // level bit and bits 3..1 are not stored
                        ctrl_reg.en  <= wdata_reg[ncr_pkg::CTL_EN_BIT];
                        ctrl_reg.oe  <= wdata_reg[ncr_pkg::CTL_OE_BIT];
                        ctrl_reg.pol <= wdata_reg[ncr_pkg::CTL_POL_BIT];
                        ctrl_reg.pfm <= wdata_reg[ncr_pkg::CTL_PFM_BIT];
                    end
                    ncr_pkg::SEL_CLOCK_SEL:
                    begin
                        // bits 4..2 dropped
                        clk_reg.pws <= wdata_reg[ncr_pkg::CLK_PWS_MSB:
                                                 ncr_pkg::CLK_PWS_LSB];
                        clk_reg.cks <= ncr_pkg::ncr_cks_t'(
                            wdata_reg[ncr_pkg::CLK_CKS_MSB:
                                      ncr_pkg::CLK_CKS_LSB]);
                    end
                    ncr_pkg::SEL_INCREMENT: inc_reg[7:0] <= wdata_reg[7:0];
                    ncr_pkg::SEL_ALT_PIN:   alt_sel_reg  <= wdata_reg[0];
                    ncr_pkg::SEL_IRQ_MASK:  mask_reg     <= wdata_reg[0];
                    default:
                    begin
                        // other registers handled elsewhere
                    end
                endcase
            end
            if (wr_lane1 && wr_sel == ncr_pkg::SEL_INCREMENT)
            begin
                inc_reg[15:8] <= wdata_reg[15:8];
            end
        end
    end

    // phase accumulator: software write beats the addition
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            acc_reg <= '0;
        end
        else if (wr_lane0 && wr_sel == ncr_pkg::SEL_ACC_LOW)
        begin
            acc_reg[7:0] <= wdata_reg[7:0];
        end
        else if (wr_lane0 && wr_sel == ncr_pkg::SEL_ACC_HIGH)
        begin
            acc_reg[15:8] <= wdata_reg[7:0];
        end
        else if (wr_lane0 && wr_sel == ncr_pkg::SEL_ACC_UPPER)
        begin
            acc_reg[19:16] <= wdata_reg[3:0];
        end
        else if (ctrl_reg.en && tick)
        begin
            acc_reg <= acc_sum[ncr_pkg::ACC_W-1:0];
        end
    end

    // output shaping: toggle or stretched pulse
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            toggle_reg    <= 1'b0;
            pulse_cnt_reg <= '0;
        end
        else if (!ctrl_reg.en)
        begin
            // disabled: output returns inactive
            toggle_reg    <= 1'b0;
            pulse_cnt_reg <= '0;
        end
        else if (overflow)
        begin
            toggle_reg    <= ~toggle_reg;
            pulse_cnt_reg <= pulse_len;
        end
        else if (tick && pulse_cnt_reg != '0)
        begin
            // width counted in accumulator clocks; an overflow during a pulse reloads the count
            pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
        end
    end

    // polarity stage and pin routing
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            level_reg          <= 1'b0;
            osc_output_level_o <= 1'b0;
            pin_main_out_o     <= 1'b0;
            pin_alt_out_o      <= 1'b0;
            pin_main_oe_n_o    <= 1'b1;
            pin_alt_oe_n_o     <= 1'b1;
        end
        else
        begin
            level_reg          <= active ^ ctrl_reg.pol;
            osc_output_level_o <= level_reg;
            pin_main_out_o     <= level_reg;
            pin_alt_out_o      <= level_reg;
            pin_main_oe_n_o    <= ~(ctrl_reg.oe & ~alt_sel_reg);
            pin_alt_oe_n_o     <= ~(ctrl_reg.oe & alt_sel_reg);
        end
    end

    // overflow sticky flag, set wins over write-one-to-clear
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            stat_reg <= 1'b0;
            irq_o    <= 1'b0;
        end
        else
        begin
            if (overflow)
            begin
                stat_reg <= 1'b1;
            end
            else if (wr_lane0 && wr_sel == ncr_pkg::SEL_IRQ_STAT &&
                     wdata_reg[0])
            begin
                stat_reg <= 1'b0;
            end
            irq_o <= stat_reg & mask_reg;
        end
    end

    // write channel: address and data taken in either order
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= '0;
            wdata_reg   <= ncr_pkg::WORD_ZERO;
            wstrb_reg   <= '0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= ncr_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid_i && awready_reg)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr_i;
                awready_reg <= 1'b0;
            end
            if (s_axi_wvalid_i && wready_reg)
            begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata_i;
                wstrb_reg  <= s_axi_wstrb_i;
                wready_reg <= 1'b0;
            end
            if (wr_do)
            begin
                // unmapped address answers with a slave error
                bvalid_reg <= 1'b1;
                bresp_reg  <= (wr_sel == ncr_pkg::SEL_NONE) ?
                              ncr_pkg::RESP_SLVERR : ncr_pkg::RESP_OKAY;
            end
            if (bvalid_reg && s_axi_bready_i)
            begin
                bvalid_reg  <= 1'b0;
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg  <= 1'b1;
            end
        end
    end

    // read channel: data returned the cycle after the address is taken
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= ncr_pkg::WORD_ZERO;
            rresp_reg   <= ncr_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid_i && arready_reg)
        begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rresp_reg   <= ncr_pkg::RESP_OKAY;
            rdata_reg   <= ncr_pkg::WORD_ZERO;
            case (reg_sel(s_axi_araddr_i))
                ncr_pkg::SEL_CONTROL:
                begin
                    rdata_reg[ncr_pkg::CTL_EN_BIT]    <= ctrl_reg.en;
                    rdata_reg[ncr_pkg::CTL_OE_BIT]    <= ctrl_reg.oe;
                    rdata_reg[ncr_pkg::CTL_LEVEL_BIT] <= level_reg;
                    rdata_reg[ncr_pkg::CTL_POL_BIT]   <= ctrl_reg.pol;
                    rdata_reg[ncr_pkg::CTL_PFM_BIT]   <= ctrl_reg.pfm;
                end
                ncr_pkg::SEL_CLOCK_SEL:
                begin
                    rdata_reg[ncr_pkg::CLK_PWS_MSB:ncr_pkg::CLK_PWS_LSB]
                        <= clk_reg.pws;
                    rdata_reg[ncr_pkg::CLK_CKS_MSB:ncr_pkg::CLK_CKS_LSB]
                        <= clk_reg.cks;
                end
                ncr_pkg::SEL_ACC_LOW:   rdata_reg[7:0]   <= acc_reg[7:0];
                ncr_pkg::SEL_ACC_HIGH:  rdata_reg[7:0]   <= acc_reg[15:8];
                ncr_pkg::SEL_ACC_UPPER: rdata_reg[3:0]   <= acc_reg[19:16];
                ncr_pkg::SEL_INCREMENT: rdata_reg[15:0]  <= inc_reg;
                ncr_pkg::SEL_ALT_PIN:   rdata_reg[0]     <= alt_sel_reg;
                ncr_pkg::SEL_IRQ_STAT:  rdata_reg[0]     <= stat_reg;
                ncr_pkg::SEL_IRQ_MASK:  rdata_reg[0]     <= mask_reg;
                default:                rresp_reg <= ncr_pkg::RESP_SLVERR;
            endcase
        end
        else if (rvalid_reg && s_axi_rready_i)
        begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // bus outputs straight from flops
    assign s_axi_awready_o = awready_reg;
    assign s_axi_wready_o  = wready_reg;
    assign s_axi_bvalid_o  = bvalid_reg;
    assign s_axi_bresp_o   = bresp_reg;
    assign s_axi_arready_o = arready_reg;
    assign s_axi_rvalid_o  = rvalid_reg;
    assign s_axi_rdata_o   = rdata_reg;
    assign s_axi_rresp_o   = rresp_reg;

endmodule

// ### hw/ncr_pkg.sv
// constants and field layouts of the oscillator control block
package ncr_pkg;
    // register byte offsets on the 32-bit bus
    localparam logic [7:0] OFF_CONTROL   = 8'h00;
    localparam logic [7:0] OFF_CLOCK_SEL = 8'h04;
    localparam logic [7:0] OFF_ACC_LOW   = 8'h08;
    localparam logic [7:0] OFF_ACC_HIGH  = 8'h0C;
    localparam logic [7:0] OFF_ACC_UPPER = 8'h10;
    localparam logic [7:0] OFF_INCREMENT = 8'h14;
    localparam logic [7:0] OFF_ALT_PIN   = 8'h18;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h1C;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h20;

    // control register field positions
    localparam int CTL_EN_BIT    = 7;
    localparam int CTL_OE_BIT    = 6;
    localparam int CTL_LEVEL_BIT = 5;
    localparam int CTL_POL_BIT   = 4;
    localparam int CTL_PFM_BIT   = 0;

    // clock select register field positions
    localparam int CLK_PWS_LSB = 5;
    localparam int CLK_PWS_MSB = 7;
    localparam int CLK_CKS_LSB = 0;
    localparam int CLK_CKS_MSB = 1;

    // accumulator byte split
    localparam int ACC_W       = 20;
    localparam int ACC_UPPER_W = 4;
    localparam int INC_W       = 16;
    localparam int PULSE_W     = 8;

    // reset values
    localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // accumulator clock source codes
    typedef enum logic [1:0] {
        CKS_FAST_OSC = 2'h0,
        CKS_SYSTEM   = 2'h1,
        CKS_CELL_ONE = 2'h2,
        CKS_EXT_PIN  = 2'h3
    } ncr_cks_t;

    // decoded register selection
    typedef enum logic [3:0] {
        SEL_NONE, SEL_CONTROL, SEL_CLOCK_SEL, SEL_ACC_LOW, SEL_ACC_HIGH,
        SEL_ACC_UPPER, SEL_INCREMENT, SEL_ALT_PIN, SEL_IRQ_STAT, SEL_IRQ_MASK
    } ncr_sel_t;

    // writable control bits
    typedef struct packed {
        logic en;
        logic oe;
        logic pol;
        logic pfm;
    } ncr_ctrl_t;

    // writable clock control bits
    typedef struct packed {
        logic [2:0] pws;
        ncr_cks_t   cks;
    } ncr_clk_t;
endpackage

// ### test/ncr_monitor.sv
// port checker for the oscillator control block
`timescale 1ns/1ps
module ncr_monitor #(
    parameter int ADDR_W = 8
) (
    input wire logic              clk_i,
    input wire logic              arst_n_i,
    input wire logic              s_axi_awvalid_i,
    input wire logic              s_axi_awready_o,
    input wire logic              s_axi_wvalid_i,
    input wire logic              s_axi_wready_o,
    input wire logic [1:0]        s_axi_bresp_o,
    input wire logic              s_axi_bvalid_o,
    input wire logic              s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic              s_axi_arvalid_i,
    input wire logic              s_axi_arready_o,
    input wire logic [31:0]       s_axi_rdata_o,
    input wire logic              s_axi_rvalid_o,
    input wire logic              s_axi_rready_i,
    input wire logic              osc_output_level_o,
    input wire logic              pin_main_out_o,
    input wire logic              pin_main_oe_n_o,
    input wire logic              pin_alt_oe_n_o
);
    logic [ADDR_W-1:0] raddr_reg; // address of the read in flight

    // read address in flight
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            raddr_reg <= '0;
        else if (s_axi_arvalid_i && s_axi_arready_o)
            raddr_reg <= s_axi_araddr_i;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    a_write_resp_time: assert property (s_axi_awvalid_i && s_axi_awready_o
        && s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
        else $error("write response late");
    a_bresp_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped");
    a_read_resp_time: assert property (s_axi_arvalid_i && s_axi_arready_o
        |=> s_axi_rvalid_o && !s_axi_arready_o)
        else $error("read response late");
    a_rdata_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped");
    a_ctrl_gap_zero: assert property (
        s_axi_rvalid_o && raddr_reg == ncr_pkg::OFF_CONTROL
        |-> s_axi_rdata_o[3:1] == 3'h0) else $error("control gap set");
    a_clk_gap_zero: assert property (
        s_axi_rvalid_o && raddr_reg == ncr_pkg::OFF_CLOCK_SEL
        |-> s_axi_rdata_o[4:2] == 3'h0) else $error("clock gap set");
    a_upper_gap_zero: assert property (
        s_axi_rvalid_o && raddr_reg == ncr_pkg::OFF_ACC_UPPER
        |-> s_axi_rdata_o[7:4] == 4'h0) else $error("upper gap set");
    a_level_readback: assert property (
        $rose(s_axi_rvalid_o) && raddr_reg == ncr_pkg::OFF_CONTROL
        |-> s_axi_rdata_o[5] == osc_output_level_o)
        else $error("level bit differs");
    a_pin_follows: assert property (
        !pin_main_oe_n_o |-> pin_main_out_o == osc_output_level_o)
        else $error("pin differs from output");
    a_one_pin_only: assert property (
        pin_main_oe_n_o || pin_alt_oe_n_o) else $error("both pins driven");

    c_slverr: cover property (s_axi_bvalid_o
        && s_axi_bresp_o == ncr_pkg::RESP_SLVERR);
    c_out_rise: cover property ($rose(osc_output_level_o));
    c_alt_pin: cover property (!pin_alt_oe_n_o);
endmodule

bind ncr_top ncr_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);

// ### test/ncr_tb_top.sv
// self-checking bench of the oscillator control block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    n_errors++; $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module ncr_tb_top;
    localparam int INC  = 32'h1000; // waveform increment
    localparam int HALF = (1 << ncr_pkg::ACC_W) / INC; // ticks per overflow
    logic        clk_i = 1'b0, arst_n_i = 1'b0; // clock, reset
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00; // addresses
    logic [31:0] wdata = 32'h0, rdata, rdv; // bus data
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp, resp; // responses
    logic [2:0]  src_on = 3'h0, ph = 3'h0; // source gates, phase
    logic        fosc = 0, lc1 = 0, ext = 0; // slow sources
    logic        lvl, pmo, pmoe, pao, paoe; // outputs
    logic [7:0]  offs [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    logic [1:0]  cks [3] = '{2'h0, 2'h2, 2'h3};   // non-system sources
    int          n_errors = 0, n_checks = 0, cyc = 0, wd;
    logic [31:0] w; // random write value
    logic        pol; // random polarity

    ncr_top dut (.clk_i, .arst_n_i,
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .fast_internal_oscillator_i(fosc),
        .logic_cell_one_output_i(lc1), .external_osc_clock_pin_i(ext),
        .osc_output_level_o(lvl), .pin_main_out_o(pmo),
        .pin_main_oe_n_o(pmoe), .pin_alt_out_o(pao),
        .pin_alt_oe_n_o(paoe), .irq_o(irq));

    // clock, slow sources, hang guard
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        ph   <= ph + 3'h1;
        fosc <= src_on[0] & ph[1];
        lc1  <= src_on[1] & ph[1];
        ext  <= src_on[2] & ph[1];
        cyc  <= cyc + 1;
        if (cyc == 60000)
        begin
            n_errors++;
            finish_test();
        end
    end

    // expected byte register readback
    function automatic logic [31:0] exp_rd(logic [7:0] a, logic [31:0] v);
        case (a)
            8'h00:   exp_rd = {24'h0, v[7:6], v[4], v[4], 3'h0, v[0]};
            8'h04:   exp_rd = v & 32'hE3;
            8'h10:   exp_rd = v & 32'h0F;
            default: exp_rd = v & 32'hFF;
        endcase
    endfunction

    // one AXI write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask

    // one AXI read
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (arready) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        rdv = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    // next whole stretch at level act
    task automatic width(input logic act, output int n);
        n = 0;
        while (lvl === act) @(posedge clk_i);
        while (lvl !== act) @(posedge clk_i);
        while (lvl === act)
        begin
            n++;
            @(posedge clk_i);
        end
    endtask

    // all byte registers read back zero
    task automatic chk_zero();
        foreach (offs[i])
        begin
            rd(offs[i]);
            `CHK("reset value", 32'h0, rdv)
        end
    endtask

    // verdict and end of run
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        w = $urandom(92231);
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        chk_zero();
        // byte register round trips
        for (int n = 0; n < 5; n++)
            foreach (offs[i])
            begin
                w = (n == 0) ? 32'hFFFF_FF7F : ($urandom & 32'hFFFF_FF7F);
                wr(offs[i], w);
                rd(offs[i]);
                `CHK("readback", exp_rd(offs[i], w), rdv)
            end
        wr(8'h24, 32'hFFFF_FFFF);
        `CHK("unmapped write", ncr_pkg::RESP_SLVERR, resp)
        rd(8'h24);
        `CHK("unmapped read", {ncr_pkg::RESP_SLVERR, 32'h0}, {resp, rdv})
        // pin drive and location
        for (int k = 0; k < 4; k++)
        begin
            wr(ncr_pkg::OFF_ALT_PIN, k & 1);
            wr(ncr_pkg::OFF_CONTROL, (k & 2) << 5);
            repeat (3) @(posedge clk_i);
            `CHK("pin enables", {k != 2, k != 3}, {pmoe, paoe})
        end
        // widths per code, both modes
        wr(ncr_pkg::OFF_INCREMENT, INC);
        for (int k = 0; k < 16; k++)
        begin
            pol = $urandom;
            wr(ncr_pkg::OFF_CLOCK_SEL, {k[3:1], 5'h01});
            wr(ncr_pkg::OFF_CONTROL, {2'h3, 1'b0, pol, 3'h0, k[0]});
            width(~pol, wd);
            `CHK("active width", k[0] ? 1 << k[3:1] : HALF, wd)
            wr(ncr_pkg::OFF_CONTROL, 32'(pol) << 4);
            repeat (4) @(posedge clk_i);
            `CHK("idle level", pol, lvl)
        end
        // overflow status, mask and clear
        rd(ncr_pkg::OFF_IRQ_STAT);
        `CHK("status", {2'h1, 1'b0}, {rdv[1:0], irq})
        wr(ncr_pkg::OFF_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clk_i);
        `CHK("irq masked in", 1'b1, irq)
        wr(ncr_pkg::OFF_IRQ_STAT, 32'h1);
        repeat (2) @(posedge clk_i);
        `CHK("irq cleared", 1'b0, irq)
        // slow source counts only when chosen
        wr(ncr_pkg::OFF_INCREMENT, 32'h1);
        foreach (cks[j])
        begin
            src_on <= 3'h7 & ~(3'h1 << j);
            wr(ncr_pkg::OFF_CLOCK_SEL, cks[j]);
            wr(ncr_pkg::OFF_CONTROL, 32'h80);
            wr(ncr_pkg::OFF_ACC_LOW, 32'h0);
            repeat (40) @(posedge clk_i);
            rd(ncr_pkg::OFF_ACC_LOW);
            `CHK("other source idle", 32'h0, rdv)
            src_on <= 3'h1 << j;
            repeat (40) @(posedge clk_i);
            rd(ncr_pkg::OFF_ACC_LOW);
            `CHK("chosen source runs", 1'b1, rdv != 0)
        end
        // reset while running
        wr(ncr_pkg::OFF_CONTROL, 32'hC1);
        repeat (30) @(posedge clk_i);
        arst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        chk_zero();
        finish_test();
    end
endmodule
